// [core/jcx_pkg.sv]
// constants, types and opcodes for the jump, compare, control and bit I/O unit
package jcx_pkg;
  localparam logic [15:0] OPC_JMP_CARRY_SET = 16'h1800;
  localparam logic [15:0] OPC_JMP_CARRY_CLR = 16'h1700;
  localparam logic [15:0] OPC_JMP_NO_OVF    = 16'h1900;
  localparam logic [15:0] OPC_JMP_ODD_PAR   = 16'h1c00;
  localparam logic [15:0] OPC_EXECUTE       = 16'h0480;
  localparam logic [15:0] OPC_CMP_WORD      = 16'h8000;
  localparam logic [15:0] OPC_CMP_BYTE      = 16'h9000;
  localparam logic [15:0] OPC_CMP_IMM       = 16'h0280;
  localparam logic [15:0] OPC_CMP_ONES      = 16'h2000;
  localparam logic [15:0] OPC_CMP_ZEROS     = 16'h2400;
  localparam logic [15:0] OPC_SYS_RESET     = 16'h0360;
  localparam logic [15:0] OPC_IDLE          = 16'h0340;
  localparam logic [15:0] OPC_CLK_OFF       = 16'h03c0;
  localparam logic [15:0] OPC_CLK_ON        = 16'h03a0;
  localparam logic [15:0] OPC_LOAD_RESTART  = 16'h03e0;
  localparam logic [15:0] OPC_BIT_ONE       = 16'h1d00;
  localparam logic [15:0] OPC_BIT_ZERO      = 16'h1e00;
  localparam logic [15:0] OPC_BIT_TEST      = 16'h1f00;
  localparam logic [15:0] OPC_MULTI_OUT     = 16'h3000;
  localparam logic [15:0] OPC_MULTI_IN      = 16'h3400;
  localparam logic [15:0] OPC_LOAD_IMM      = 16'h0200;
  localparam logic [15:0] MASK_JMP          = 16'hff00;
  localparam logic [15:0] MASK_TWO_OPND     = 16'hf000;
  localparam logic [15:0] MASK_REG_OPND     = 16'hffe0;
  localparam logic [15:0] MASK_SRC_OPND     = 16'hffc0;
  localparam logic [15:0] MASK_CNT_OPND     = 16'hfc00;
  // status bit positions, bit 0 of the word is index 15
  localparam int STAT_LGT   = 15;
  localparam int STAT_AGT   = 14;
  localparam int STAT_EQ    = 13;
  localparam int STAT_CARRY = 12;
  localparam int STAT_OVF   = 11;
  localparam int STAT_PAR   = 10;
  localparam int STAT_PRIV  = 8;
  localparam int STAT_MAP   = 7;
  localparam int STAT_MASK_LSB = 0;
  localparam int CNT_LSB    = 6;
  localparam logic [15:0] STATUS_RESET   = 16'h0000;
  localparam logic [15:0] RESTART_VECTOR = 16'hfffc;
  localparam logic [11:0] PRIV_IO_LIMIT  = 12'he00;
  localparam logic [4:0]  BYTE_CNT_LIMIT = 5'd9;
  localparam logic [4:0]  FULL_CNT       = 5'd16;

  typedef enum logic [4:0] {
    OP_NONE, OP_JC_SET, OP_JC_CLR, OP_J_NOVF, OP_J_PAR, OP_EXEC,
    OP_CMPW, OP_CMPB, OP_CMPI, OP_CMP1, OP_CMP0, OP_RESET, OP_IDLE,
    OP_CKOFF, OP_LINE_CLOCK_ENABLE, OP_RESTART, OP_BIT1, OP_BIT0, OP_BITT,
    OP_MOUT, OP_MIN, OP_LDI
  } jcx_op_e;

  typedef struct packed {
    logic [15:0] instr;
    logic [15:0] pc_next;
    logic [15:0] src_addr;
    logic [15:0] src_data;
    logic [15:0] dst_data;
    logic [15:0] ws_data;
    logic [15:0] imm;
    logic [15:0] wr12;
  } jcx_req_s;

  typedef struct packed {
    logic [11:0] addr;
    logic        data;
    logic        we;
    logic        re;
  } jcx_bit_s;

  typedef struct packed {
    logic sys_reset;
    logic clk_off;
    logic clk_on;
    logic restart;
  } jcx_ext_s;
endpackage : jcx_pkg

// [core/jcx_exec_unit.sv]
// execution unit for jumps, compares, control ops and bit-serial I/O
module jcx_exec_unit
  import jcx_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        variant_single_chip,
  input  wire logic        variant_mapped,
  input  wire logic        map_option_present,
  input  wire logic        req_valid,
  input  wire jcx_req_s    req,
  output logic             req_ready,
  input  wire logic        irq_pending,
  input  wire logic        status_load,
  input  wire logic [15:0] status_load_data,
  output logic [15:0]      status_word,
  output logic [15:0]      pc_out,
  output logic             pc_load,
  output logic             exec_fetch_req,
  output logic [15:0]      exec_fetch_addr,
  output logic             ctx_switch_req,
  output logic [15:0]      ctx_vector_addr,
  output logic             ws_write,
  output logic [15:0]      ws_write_data,
  output logic             mem_write,
  output logic [15:0]      mem_write_addr,
  output logic [15:0]      mem_write_data,
  output jcx_bit_s         bit_io,
  input  wire logic        bit_in,
  output logic             line_clock_on,
  output logic             io_reset,
  output logic             int_flush,
  output jcx_ext_s         ext_ctl,
  output logic             idle_active,
  output logic             error_int,
  output logic             done
);

  typedef enum logic [2:0] {
    S_READY, S_OUT, S_IN, S_IN_LAST, S_STORE, S_TEST, S_HALT
  } jcx_state_e;

  function automatic jcx_op_e op_decode(input logic [15:0] w);
    jcx_op_e o;
    o = OP_NONE;
    if ((w & MASK_JMP) == OPC_JMP_CARRY_SET) o = OP_JC_SET;
    else if ((w & MASK_JMP) == OPC_JMP_CARRY_CLR) o = OP_JC_CLR;
    else if ((w & MASK_JMP) == OPC_JMP_NO_OVF) o = OP_J_NOVF;
    else if ((w & MASK_JMP) == OPC_JMP_ODD_PAR) o = OP_J_PAR;
    else if ((w & MASK_JMP) == OPC_BIT_ONE) o = OP_BIT1;
    else if ((w & MASK_JMP) == OPC_BIT_ZERO) o = OP_BIT0;
    else if ((w & MASK_JMP) == OPC_BIT_TEST) o = OP_BITT;
    else if ((w & MASK_SRC_OPND) == OPC_EXECUTE) o = OP_EXEC;
    else if ((w & MASK_TWO_OPND) == OPC_CMP_WORD) o = OP_CMPW;
    else if ((w & MASK_TWO_OPND) == OPC_CMP_BYTE) o = OP_CMPB;
    else if ((w & MASK_REG_OPND) == OPC_CMP_IMM) o = OP_CMPI;
    else if ((w & MASK_REG_OPND) == OPC_LOAD_IMM) o = OP_LDI;
    else if ((w & MASK_CNT_OPND) == OPC_CMP_ONES) o = OP_CMP1;
    else if ((w & MASK_CNT_OPND) == OPC_CMP_ZEROS) o = OP_CMP0;
    else if ((w & MASK_CNT_OPND) == OPC_MULTI_OUT) o = OP_MOUT;
    else if ((w & MASK_CNT_OPND) == OPC_MULTI_IN) o = OP_MIN;
    else if ((w & MASK_REG_OPND) == OPC_SYS_RESET) o = OP_RESET;
    else if ((w & MASK_REG_OPND) == OPC_IDLE) o = OP_IDLE;
    else if ((w & MASK_REG_OPND) == OPC_CLK_OFF) o = OP_CKOFF;
    else if ((w & MASK_REG_OPND) == OPC_CLK_ON) o = OP_LINE_CLOCK_ENABLE;
    else if ((w & MASK_REG_OPND) == OPC_LOAD_RESTART) o = OP_RESTART;
    return o;
  endfunction : op_decode

  // logical greater, arithmetic greater, equal
  function automatic logic [2:0] cmp_flags(input logic [15:0] a,
                                           input logic [15:0] b);
    return {a > b, $signed(a) > $signed(b), a == b};
  endfunction : cmp_flags

  jcx_state_e  state_reg;
  jcx_state_e  state_next;
  logic [15:0] status_reg;
  logic [15:0] status_next;
  logic [15:0] shift_reg;
  logic [4:0]  idx_reg;
  logic [4:0]  nbits_reg;
  logic [11:0] base_reg;
  logic [15:0] dest_reg;
  logic        idle_ext_reg;

  jcx_op_e     op;
  logic        accept;
  logic        priv_trap;
  logic        ctl_op;
  logic        bit_op;
  logic        trap;
  logic        internal;
  logic [15:0] disp;
  logic [15:0] jmp_target;
  logic        jmp_taken;
  logic        is_jump;
  logic [11:0] io_addr;
  logic [4:0]  nbits;
  logic [15:0] mout_val;
  logic [15:0] min_res;
  logic [15:0] min_word;
  logic        last_bit;

  assign op        = op_decode(req.instr);
  assign req_ready = (state_reg == S_READY);
  assign accept    = req_valid && req_ready;
  assign priv_trap = variant_mapped && status_reg[STAT_PRIV];
  assign ctl_op    = (op == OP_RESET) || (op == OP_IDLE) || (op == OP_CKOFF)
                     || (op == OP_LINE_CLOCK_ENABLE) || (op == OP_RESTART);
  assign bit_op    = (op == OP_BIT1) || (op == OP_BIT0) || (op == OP_BITT)
                     || (op == OP_MOUT) || (op == OP_MIN);
  assign internal  = !variant_single_chip;
  assign disp = {{8{req.instr[7]}}, req.instr[7:0]};
  // word displacement doubled onto advanced counter
  assign jmp_target = req.pc_next + {disp[14:0], 1'b0};
  // bit address from register 12 plus displacement, register 12 alone for multi-bit out and in
  assign io_addr = (op == OP_MOUT || op == OP_MIN) ? req.wr12[12:1]
                   : req.wr12[12:1] + disp[11:0];
  // privileged bit I/O at or above the limit traps
  assign trap = priv_trap && (ctl_op || (bit_op && io_addr >= PRIV_IO_LIMIT));
  assign nbits = (req.instr[CNT_LSB+:4] == 4'h0) ? FULL_CNT
                 : {1'b0, req.instr[CNT_LSB+:4]};
  assign mout_val = (nbits < BYTE_CNT_LIMIT) ? {8'h00, req.src_data[15:8]}
                    : req.src_data;
  assign min_res  = shift_reg >> (FULL_CNT - nbits_reg);
  assign min_word = (nbits_reg < BYTE_CNT_LIMIT) ? {min_res[7:0], 8'h00}
                    : min_res;
  assign last_bit = (idx_reg == nbits_reg - 5'd1);
  assign is_jump  = (op == OP_JC_SET) || (op == OP_JC_CLR)
                    || (op == OP_J_NOVF) || (op == OP_J_PAR);

  always_comb begin
    unique case (op)
      OP_JC_SET: jmp_taken = status_reg[STAT_CARRY];
      OP_JC_CLR: jmp_taken = !status_reg[STAT_CARRY];
      OP_J_NOVF: jmp_taken = !status_reg[STAT_OVF];
      OP_J_PAR:  jmp_taken = status_reg[STAT_PAR];
      default:   jmp_taken = 1'b0;
    endcase
  end

  always_comb begin
    status_next = status_reg;
    unique case (op)
      OP_CMPW: status_next[STAT_LGT-:3] = cmp_flags(req.src_data, req.dst_data);
      OP_CMPI: status_next[STAT_LGT-:3] = cmp_flags(req.ws_data, req.imm);
      OP_CMPB: begin
        status_next[STAT_LGT-:3] = cmp_flags({req.src_data[15:8], 8'h00},
                                             {req.dst_data[15:8], 8'h00});
        status_next[STAT_PAR] = ^req.src_data[15:8];
      end
      OP_CMP1: status_next[STAT_EQ] = ((req.ws_data & req.src_data) == req.src_data);
      OP_CMP0: status_next[STAT_EQ] = ((req.ws_data & req.src_data) == 16'h0000);
      OP_LDI: status_next[STAT_LGT-:3] = cmp_flags(req.imm, 16'h0000);
      OP_MOUT: begin
        status_next[STAT_LGT-:3] = (nbits < BYTE_CNT_LIMIT)
          ? cmp_flags({mout_val[7:0], 8'h00}, 16'h0000)
          : cmp_flags(mout_val, 16'h0000);
        if (nbits < BYTE_CNT_LIMIT) status_next[STAT_PAR] = ^mout_val[7:0];
      end
      // reset clears mask when done internally
      OP_RESET: if (internal) status_next[STAT_MASK_LSB+:4] = 4'h0;
      OP_RESTART: if (internal) begin
        status_next[STAT_MASK_LSB+:4] = 4'h0;
        if (map_option_present) status_next[STAT_MAP] = 1'b0;
      end
      default: status_next = status_reg;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      S_READY: if (accept && !trap) begin
        if (op == OP_MOUT) state_next = S_OUT;
        else if (op == OP_MIN) state_next = S_IN;
        else if (op == OP_BITT) state_next = S_TEST;
        else if (op == OP_IDLE) state_next = S_HALT;
      end
      S_OUT: if (last_bit) state_next = S_READY;
      S_IN: if (last_bit) state_next = S_IN_LAST;
      S_IN_LAST: state_next = S_STORE;
      S_STORE: state_next = S_READY;
      S_TEST: state_next = S_READY;
      S_HALT: if (irq_pending) state_next = S_READY;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) state_reg <= S_READY;
    else state_reg <= state_next;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) status_reg <= STATUS_RESET;
    else if (accept && !trap) status_reg <= status_next;
    else if (state_reg == S_TEST) status_reg[STAT_EQ] <= bit_in;
    else if (state_reg == S_STORE) begin
      status_reg[STAT_LGT-:3] <= cmp_flags(min_word, 16'h0000);
      if (nbits_reg < BYTE_CNT_LIMIT) status_reg[STAT_PAR] <= ^min_res[7:0];
    end
    else if (status_load) status_reg <= status_load_data;
  end
  assign status_word = status_reg;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pc_out  <= 16'h0000;
      pc_load <= 1'b0;
    end else begin
      pc_load <= accept && is_jump;
      if (accept && is_jump) pc_out <= jmp_taken ? jmp_target : req.pc_next;
    end
  end

  // multi-bit shift state
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      shift_reg <= 16'h0000;
      idx_reg   <= 5'd0;
      nbits_reg <= 5'd0;
      base_reg  <= 12'h000;
      dest_reg  <= 16'h0000;
    end else if (accept) begin
      shift_reg <= mout_val;
      idx_reg   <= 5'd0;
      nbits_reg <= nbits;
      base_reg  <= io_addr;
      dest_reg  <= req.src_addr;
    end else if (state_reg == S_OUT || state_reg == S_IN) begin
      idx_reg <= idx_reg + 5'd1;
      if (state_reg == S_OUT) shift_reg <= {1'b0, shift_reg[15:1]};
    end else if (bit_io.re && state_reg == S_IN_LAST) begin
      shift_reg <= {bit_in, shift_reg[15:1]};
    end
    if (reset_n && bit_io.re && state_reg == S_IN) begin
      shift_reg <= {bit_in, shift_reg[15:1]};
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bit_io <= '0;
    end else begin
      bit_io.we <= 1'b0;
      bit_io.re <= 1'b0;
      if (accept && !trap && (op == OP_BIT1 || op == OP_BIT0)) begin
        bit_io.we   <= 1'b1;
        bit_io.addr <= io_addr;
        bit_io.data <= (op == OP_BIT1);
      end else if (accept && !trap && op == OP_BITT) begin
        bit_io.re   <= 1'b1;
        bit_io.addr <= io_addr;
      end else if (state_reg == S_OUT) begin
        bit_io.we   <= 1'b1;
        bit_io.addr <= base_reg + {7'd0, idx_reg};
        bit_io.data <= shift_reg[0];
      end else if (state_reg == S_IN) begin
        bit_io.re   <= 1'b1;
        bit_io.addr <= base_reg + {7'd0, idx_reg};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mem_write      <= 1'b0;
      mem_write_addr <= 16'h0000;
      mem_write_data <= 16'h0000;
      ws_write       <= 1'b0;
      ws_write_data  <= 16'h0000;
    end else begin
      mem_write <= (state_reg == S_STORE);
      if (state_reg == S_STORE) begin
        mem_write_addr <= dest_reg;
        mem_write_data <= min_word;
      end
      ws_write <= accept && (op == OP_LDI);
      if (accept && op == OP_LDI) ws_write_data <= req.imm;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      exec_fetch_req  <= 1'b0;
      exec_fetch_addr <= 16'h0000;
      ctx_switch_req  <= 1'b0;
      ctx_vector_addr <= 16'h0000;
    end else begin
      exec_fetch_req <= accept && (op == OP_EXEC);
      if (accept && op == OP_EXEC) exec_fetch_addr <= req.src_addr;
      ctx_switch_req <= accept && !trap && internal && (op == OP_RESTART);
      if (accept && op == OP_RESTART) ctx_vector_addr <= RESTART_VECTOR;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      line_clock_on <= 1'b0;
      io_reset      <= 1'b0;
      int_flush     <= 1'b0;
    end else begin
      io_reset  <= accept && !trap && internal && (op == OP_RESET);
      int_flush <= accept && !trap && internal && (op == OP_RESET);
      if (accept && !trap && internal) begin
        if (op == OP_CKOFF || op == OP_RESET) line_clock_on <= 1'b0;
        else if (op == OP_LINE_CLOCK_ENABLE) line_clock_on <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ext_ctl      <= '0;
      idle_ext_reg <= 1'b0;
    end else begin
      ext_ctl.sys_reset <= accept && !trap && !internal && (op == OP_RESET);
      ext_ctl.clk_off   <= accept && !trap && !internal && (op == OP_CKOFF);
      ext_ctl.clk_on    <= accept && !trap && !internal && (op == OP_LINE_CLOCK_ENABLE);
      ext_ctl.restart   <= accept && !trap && !internal && (op == OP_RESTART);
      if (accept && !trap && op == OP_IDLE) idle_ext_reg <= variant_single_chip;
      else if (state_reg == S_HALT && irq_pending) idle_ext_reg <= 1'b0;
    end
  end
  assign idle_active = idle_ext_reg;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      error_int <= 1'b0;
      done      <= 1'b0;
    end else begin
      error_int <= accept && trap;
      done <= (accept && (trap || state_next == S_READY))
              || (state_reg == S_OUT && last_bit)
              || state_reg == S_STORE || state_reg == S_TEST
              || (state_reg == S_HALT && irq_pending);
    end
  end

endmodule : jcx_exec_unit

// [verification/jcx_bit_dev.sv]
// bit-serial io device model facing the exec unit
module jcx_bit_dev
  import jcx_pkg::*;
(
  input  wire logic     clk,
  input  wire jcx_bit_s bit_io,
  input  wire logic     io_reset,
  input  wire jcx_ext_s ext_ctl,
  output logic          bit_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic mem [0:4095];
  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = 1'b0;
  end
  assign bit_in = bit_io.re ? mem[bit_io.addr] : ~mem[bit_io.addr];
  always @(posedge clk) begin
    if (io_reset || ext_ctl.sys_reset) begin
      for (int i = 0; i < 4096; i++) mem[i] <= 1'b0;
    end else if (bit_io.we) begin
      mem[bit_io.addr] <= bit_io.data;
    end
  end
endmodule : jcx_bit_dev

// [verification/jcx_exec_unit_assertions.sv]
// port checker for the exec unit
module jcx_exec_unit_assertions
  import jcx_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        variant_single_chip,
  input wire logic        variant_mapped,
  input wire logic        req_valid,
  input wire jcx_req_s    req,
  input wire logic        req_ready,
  input wire logic [15:0] status_word,
  input wire logic [15:0] pc_out,
  input wire logic        pc_load,
  input wire logic        ctx_switch_req,
  input wire logic [15:0] ctx_vector_addr,
  input wire logic        ws_write,
  input wire logic [15:0] ws_write_data,
  input wire jcx_bit_s    bit_io,
  input wire logic        line_clock_on,
  input wire jcx_ext_s    ext_ctl,
  input wire logic        idle_active,
  input wire logic        error_int
);
  timeunit 1ns;
  timeprecision 100ps;
  logic        take;
  logic        trap;
  logic        ctl;
  logic [15:0] tgt;
  logic [11:0] badr;
  assign take = req_valid && req_ready;
  assign trap = variant_mapped && status_word[8];
  assign ctl  = req.instr inside {16'h0340, 16'h0360, 16'h03a0, 16'h03c0, 16'h03e0};
  assign tgt  = req.pc_next + {{7{req.instr[7]}}, req.instr[7:0], 1'b0};
  assign badr = req.wr12[12:1] + {{4{req.instr[7]}}, req.instr[7:0]};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence op_s(logic [15:0] m, logic [15:0] o);
    take && ((req.instr & m) == o);
  endsequence
  carry_jump_a:
    assert property (op_s(16'hff00, 16'h1800) ##0 status_word[12]
      |=> pc_load && pc_out == $past(tgt)) else $error("carry jump wrong");
  parity_hold_a:
    assert property (op_s(16'hff00, 16'h1c00) ##0 !status_word[10]
      |=> pc_load && pc_out == $past(req.pc_next)) else $error("parity jump taken");
  word_cmp_a:
    assert property (op_s(16'hf000, 16'h8000) |=> status_word[12:0] == $past(status_word[12:0])
      && status_word[13] == ($past(req.src_data) == $past(req.dst_data)))
      else $error("word compare flags wrong");
  restart_vec_a:
    assert property (op_s(16'hffff, 16'h03e0) ##0 !trap && !variant_single_chip
      |=> ctx_switch_req && ctx_vector_addr == 16'hfffc && status_word[3:0] == 4'h0)
      else $error("restart wrong");
  ctl_trap_a:
    assert property (take && ctl && trap |=> error_int && !ctx_switch_req && ext_ctl == '0)
      else $error("privileged op not trapped");
  ext_only_a:
    assert property (op_s(16'hffff, 16'h03a0) ##0 variant_single_chip && !trap
      |=> ext_ctl.clk_on && $stable(line_clock_on) ##1 $stable(line_clock_on))
      else $error("clock on not only signalled");
  idle_block_a:
    assert property (idle_active |-> !req_ready) else $error("ready while idle");
  bit_one_a:
    assert property (op_s(16'hff00, 16'h1d00) ##0 !(trap && badr >= 12'he00)
      |=> bit_io.we && bit_io.data && bit_io.addr == $past(badr)) else $error("bit set wrong");
  ldi_write_a:
    assert property (op_s(16'hffe0, 16'h0200) |=> ws_write && ws_write_data == $past(req.imm))
      else $error("load immediate wrong");
endmodule : jcx_exec_unit_assertions

bind jcx_exec_unit jcx_exec_unit_assertions chk_u (
  .clk, .reset_n, .variant_single_chip, .variant_mapped, .req_valid, .req, .req_ready,
  .status_word, .pc_out, .pc_load, .ctx_switch_req, .ctx_vector_addr, .ws_write,
  .ws_write_data, .bit_io, .line_clock_on, .ext_ctl, .idle_active, .error_int);

// [verification/test_cpu_jump_compare_control_io_exec.sv]
// self-checking bench for the exec unit
module test_cpu_jump_compare_control_io_exec
  import jcx_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;
  logic        reset_n, variant_single_chip, variant_mapped, map_option_present;
  logic        req_valid, req_ready, irq_pending, status_load, pc_load, exec_fetch_req;
  logic        ctx_switch_req, ws_write, mem_write, bit_in, line_clock_on, io_reset;
  logic        int_flush, idle_active, error_int, done;
  logic [15:0] status_load_data, status_word, pc_out, exec_fetch_addr, ctx_vector_addr;
  logic [15:0] ws_write_data, mem_write_addr, mem_write_data, sv, e, a, b;
  logic [11:0] seen;
  jcx_req_s    req, r;
  jcx_bit_s    bit_io;
  jcx_ext_s    ext_ctl;
  int          err_total = 0;
  int          tests_run = 0;
  int          seed = 76;
  int          ji[4] = '{12, 12, 11, 10};
  logic [3:0]  jp = 4'b1001;
  logic [15:0] jq[4] = '{16'h1800, 16'h1700, 16'h1900, 16'h1c00};
  logic [15:0] cq[$] = '{16'h8000, 16'h0280, 16'h9000, 16'h2000, 16'h2400, 16'h0200};
  logic [15:0] xq[$] = '{16'h0360, 16'h03c0, 16'h03a0, 16'h03e0, 16'h0340};

  jcx_exec_unit dut_u (
    .clk, .reset_n, .variant_single_chip, .variant_mapped, .map_option_present, .req_valid,
    .req, .req_ready, .irq_pending, .status_load, .status_load_data, .status_word, .pc_out,
    .pc_load, .exec_fetch_req, .exec_fetch_addr, .ctx_switch_req, .ctx_vector_addr,
    .ws_write, .ws_write_data, .mem_write, .mem_write_addr, .mem_write_data, .bit_io,
    .bit_in, .line_clock_on, .io_reset, .int_flush, .ext_ctl, .idle_active, .error_int, .done);
  jcx_bit_dev dev_u (.clk, .bit_io, .io_reset, .ext_ctl, .bit_in);

  always #12.5 clk = ~clk;

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic setst(input logic [15:0] v);
    @(posedge clk);
    status_load <= 1'b1;
    status_load_data <= v;
    @(posedge clk);
    status_load <= 1'b0;
  endtask : setst

  task automatic issue(input jcx_req_s q);
    int n = 0;
    @(posedge clk);
    req <= q;
    req_valid <= 1'b1;
    #1;
    while (req_ready !== 1'b1 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (req_ready !== 1'b1) chk(40'h0, 40'h1);
    @(posedge clk);
    req_valid <= 1'b0;
    seen = '0;
    n = 0;
    // pulses stand in the cycle right after the take edge
    do begin
      if (n > 0) @(posedge clk);
      #1;
      seen |= {error_int, ctx_switch_req, io_reset, int_flush, ext_ctl, ws_write, pc_load,
               mem_write, exec_fetch_req};
      n++;
    end while (done !== 1'b1 && n < 100);
    if (done !== 1'b1) chk(40'h0, 40'h1);
    // last bit line write lands one edge after done
    @(posedge clk);
    #1;
  endtask : issue

  function automatic jcx_req_s rq(input logic [15:0] ins);
    jcx_req_s q;
    q = {$random(seed), $random(seed), $random(seed), $random(seed)};
    q.instr = ins;
    return q;
  endfunction : rq

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  initial begin
    #(25 * 20000);
    chk(40'h0, 40'h1);
    final_report();
  end

  initial begin
    {reset_n, variant_single_chip, variant_mapped, req_valid, irq_pending} = '0;
    {status_load, status_load_data, req} = '0;
    map_option_present = 1'b1;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    for (int k = 0; k < 16; k++) begin
      sv = 16'($random(seed));
      sv[ji[k % 4]] = k[2];
      setst(sv);
      r = rq(jq[k % 4]);
      r.instr[7:0] = 8'($random(seed));
      issue(r);
      e = (k[2] == jp[k % 4]) ? r.pc_next + {{7{r.instr[7]}}, r.instr[7:0], 1'b0} : r.pc_next;
      chk({seen[2], pc_out}, {1'b1, e});
    end
    for (int k = 0; k < 12; k++) begin
      sv = 16'($random(seed));
      setst(sv);
      r = rq(cq[k % 6]);
      if (k > 5) begin
        r.ws_data = k[0] ? r.ws_data | r.src_data : r.ws_data & ~r.src_data;
        r.dst_data = r.src_data;
        r.imm = k == 11 ? 16'h0 : r.ws_data;
      end
      issue(r);
      e = sv;
      {a, b} = r.instr == 16'h0280 ? {r.ws_data, r.imm} : {r.src_data, r.dst_data};
      if (r.instr == 16'h9000) {a, b} = {a[15:8], 8'h00, b[15:8], 8'h00};
      if (r.instr == 16'h9000) e[10] = ^a;
      if (r.instr == 16'h0200) {a, b} = {r.imm, 16'h0};
      e[15:13] = {a > b, $signed(a) > $signed(b), a == b};
      if (r.instr[13]) e[15:13] = {sv[15:14], (r.ws_data & r.src_data) ==
                                   (r.instr[10] ? 16'h0 : r.src_data)};
      chk({seen, status_word}, {r.instr == 16'h0200 ? 12'h008 : 12'h000, e});
      if (r.instr == 16'h0200) chk(ws_write_data, r.imm);
    end
    r = rq(16'h0480);
    issue(r);
    chk({seen[0], exec_fetch_addr}, {1'b1, r.src_addr});
    setst(16'h018f);
    for (int j = 0; j < 3; j++) begin
      issue(rq(j == 1 ? 16'h03c0 : 16'h03a0));
      chk({line_clock_on, status_word}, {j != 1, 16'h018f});
    end
    issue(rq(16'h0360));
    chk({seen, line_clock_on, status_word}, {12'h300, 1'b0, 16'h0180});
    setst(16'h018f);
    issue(rq(16'h03e0));
    chk({seen, ctx_vector_addr, status_word}, {12'h400, 16'hfffc, 16'h0100});
    @(posedge clk) variant_mapped <= 1'b1;
    foreach (xq[i]) begin
      issue(rq(xq[i]));
      chk({seen, line_clock_on, status_word}, {12'h800, 1'b0, 16'h0100});
    end
    for (int k = 0; k < 6; k++) begin
      r = rq(k[0] && k < 4 ? 16'h1ffe : k == 2 ? 16'h1efe : k > 3 ? 16'h1d00 : 16'h1dfe);
      r.wr12 = k == 4 ? 16'h1c00 : k == 5 ? 16'h1bfe : 16'h0040;
      issue(r);
      if (k < 4) chk(k[0] ? status_word[13] : dev_u.mem[12'h01e], k < 2);
      else chk({seen[11], dev_u.mem[k == 4 ? 12'he00 : 12'hdff]}, {k == 4, k == 5});
    end
    r = rq(16'h30c0);
    r.wr12 = 16'h0100;
    issue(r);
    chk({dev_u.mem[12'h082], dev_u.mem[12'h081], dev_u.mem[12'h080]}, r.src_data[10:8]);
    a = {5'h0, r.src_data[10:8], 8'h00};
    r = rq(16'h34c0);
    r.wr12 = 16'h0100;
    issue(r);
    chk({mem_write_addr, mem_write_data}, {r.src_addr, a});
    chk(status_word & 16'he400, {a != 0, a != 0, a == 0, 2'b00, ^a, 10'h0});
    @(posedge clk);
    variant_mapped <= 1'b0;
    variant_single_chip <= 1'b1;
    setst(16'h010f);
    for (int i = 0; i < 4; i++) begin
      issue(rq(xq[i]));
      chk({seen, line_clock_on, status_word}, {12'h080 >> i, 1'b0, 16'h010f});
    end
    fork
      issue(rq(16'h0340));
      begin
        repeat (8) @(posedge clk);
        #1 chk({idle_active, req_ready}, 2'b10);
        @(posedge clk) irq_pending <= 1'b1;
      end
    join
    @(posedge clk) irq_pending <= 1'b0;
    final_report();
  end
endmodule : test_cpu_jump_compare_control_io_exec
